/* File: hdl/pbrt_consts.svh */
/*
  timing constants for the push-button reset timer.
  assumes a 200 MHz core clock; counts derive from printed times.
*/
// Behaviour
// - dual inputs: both low beyond hold time
// - single input: first button low beyond hold
// - input variant: release when a required button rises
// - pulse variant: release after 400/80 ms
// - reset output active low, open drain
// - select picks 7.5 s, or 12.5/0 s
// - zero hold: assert after 150 us detect
// - wait 300 us start-up, then act
// - one reset per condition; release needed
// - ignore input glitches during fixed pulse
// - sample select at power-up or button high
`ifndef PBRT_CONSTS_SVH
`define PBRT_CONSTS_SVH
`define PBRT_CLK_MHZ 200
`define PBRT_HOLD_LOW_MS 7500
`define PBRT_HOLD_HIGH_IN_MS 12500
`define PBRT_HOLD_HIGH_FIX_MS 0
`define PBRT_PULSE_G_MS 400
`define PBRT_PULSE_C_MS 80
`define PBRT_DETECT_DELAY_US 150
`define PBRT_STARTUP_DELAY_US 300
`define PBRT_MS_CYC(ms) ((ms) * 1000 * `PBRT_CLK_MHZ)
`define PBRT_US_CYC(us) ((us) * `PBRT_CLK_MHZ)
`endif

/* File: hdl/pbrt_counter.sv */
/*
  up counter with clear and terminal flag.
  assumes synchronous clear from the owner.
*/
`timescale 1ns/100ps
module pbrt_counter #(
  parameter int WIDTH = 40
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire logic [WIDTH-1:0] i_limit,
  output logic o_done
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } pbrt_cnt_state_t;
  pbrt_cnt_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (i_clear) begin
      s_d.cnt = '0;
    end else if (s_q.cnt < i_limit) begin
      s_d.cnt = s_q.cnt + WIDTH'(1);
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // done only once the limit is reached, not on clear
  assign o_done = !i_clear && (s_q.cnt >= i_limit);
endmodule

/* File: hdl/pbrt_pkg.sv */
/*
  types for the push-button reset timer.
  assumes nothing beyond the constants header.
*/
package pbrt_pkg;
  typedef enum logic [1:0] {
    PBRT_INPUT_DEP,
    PBRT_FIXED_G,
    PBRT_FIXED_C
  } pbrt_variant_t;
  typedef enum logic [1:0] {
    PBRT_ST_STARTUP,
    PBRT_ST_ARMED,
    PBRT_ST_RESET,
    PBRT_ST_WAIT_REL
  } pbrt_state_t;
endpackage

/* File: hdl/pbrt_top.sv */
/*
  push-button reset timer: holds, pulse and start-up timing.
  assumes button inputs and select synchronous to I_CORE_CLK;
  the pad resolves the open-drain reset from the enable.
*/
`timescale 1ns/100ps
`include "pbrt_consts.svh"
module pbrt_top #(
  parameter pbrt_pkg::pbrt_variant_t VARIANT = pbrt_pkg::PBRT_FIXED_G,
  parameter bit DUAL_INPUT = 1'b1,
  parameter int CW = 40,
  parameter longint HOLD_LOW_CYC = `PBRT_MS_CYC(`PBRT_HOLD_LOW_MS),
  parameter longint HOLD_HIGH_IN_CYC = `PBRT_MS_CYC(`PBRT_HOLD_HIGH_IN_MS),
  parameter longint PULSE_G_CYC = `PBRT_MS_CYC(`PBRT_PULSE_G_MS),
  parameter longint PULSE_C_CYC = `PBRT_MS_CYC(`PBRT_PULSE_C_MS),
  parameter longint DETECT_CYC = `PBRT_US_CYC(`PBRT_DETECT_DELAY_US),
  parameter longint STARTUP_CYC = `PBRT_US_CYC(`PBRT_STARTUP_DELAY_US)
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic I_FIRST_BUTTON_IN_N,
  input wire logic I_SECOND_BUTTON_IN_N,
  input wire logic I_DELAY_SELECT,
  output logic O_RESET_OUT,
  output logic O_RESET_OE,
  output logic O_RESET_ACTIVE_N
);
  typedef struct packed {
    pbrt_pkg::pbrt_state_t st;
    logic sel;
    logic oe;
    logic rst_n;
    logic drv; // open-drain data bit, always low so the enable alone pulls
  } pbrt_state_s_t;
  pbrt_state_s_t s_q, s_d;

  logic first_low, pressed, released;
  logic hold_done, pulse_done, start_done;
  logic hold_clr, pulse_clr;
  logic [CW-1:0] hold_lim, pulse_lim;

  assign first_low = !I_FIRST_BUTTON_IN_N;
  // single-input variant ignores the second pin
  assign pressed = DUAL_INPUT ? (first_low && !I_SECOND_BUTTON_IN_N) : first_low;
  assign released = !pressed;

  // hold time by variant and latched select
  always_comb begin
    if (!s_q.sel) begin
      hold_lim = CW'(HOLD_LOW_CYC);
    end else if (VARIANT == pbrt_pkg::PBRT_INPUT_DEP) begin
      hold_lim = CW'(HOLD_HIGH_IN_CYC);
    end else begin
      hold_lim = CW'(DETECT_CYC); // zero hold still has detect delay
    end
  end
  assign pulse_lim = (VARIANT == pbrt_pkg::PBRT_FIXED_C) ? CW'(PULSE_C_CYC) : CW'(PULSE_G_CYC);

  // hold counter restarts whenever a required input is high
  assign hold_clr = released || (s_q.st != pbrt_pkg::PBRT_ST_ARMED);
  assign pulse_clr = (s_q.st != pbrt_pkg::PBRT_ST_RESET);

  pbrt_counter #(.WIDTH(CW)) u_start (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(1'b0),
    .i_limit(CW'(STARTUP_CYC)),
    .o_done(start_done)
  );
  pbrt_counter #(.WIDTH(CW)) u_hold (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(hold_clr),
    .i_limit(hold_lim),
    .o_done(hold_done)
  );
  pbrt_counter #(.WIDTH(CW)) u_pulse (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .i_clear(pulse_clr),
    .i_limit(pulse_lim),
    .o_done(pulse_done)
  );

  always_comb begin
    s_d = s_q;
    // select tracked during start-up or while any required button is high, frozen otherwise
    if (released) begin
      s_d.sel = I_DELAY_SELECT;
    end
    unique case (s_q.st)
      pbrt_pkg::PBRT_ST_STARTUP: begin
        // select caught during start-up window
        s_d.sel = I_DELAY_SELECT;
        if (start_done) begin
          s_d.st = pbrt_pkg::PBRT_ST_ARMED; // act only after start-up
        end
      end
      pbrt_pkg::PBRT_ST_ARMED: begin
        if (pressed && hold_done) begin
          s_d.st = pbrt_pkg::PBRT_ST_RESET;
        end
      end
      pbrt_pkg::PBRT_ST_RESET: begin
        if (VARIANT == pbrt_pkg::PBRT_INPUT_DEP) begin
          if (released) begin
            s_d.st = pbrt_pkg::PBRT_ST_ARMED;
          end
        end else if (pulse_done) begin
          // inputs not looked at while pulsing, so glitches vanish
          s_d.st = pbrt_pkg::PBRT_ST_WAIT_REL;
        end
      end
      pbrt_pkg::PBRT_ST_WAIT_REL: begin
        // a fresh press needs a release first
        if (released) begin
          s_d.st = pbrt_pkg::PBRT_ST_ARMED;
        end
      end
    endcase
    s_d.oe = (s_d.st == pbrt_pkg::PBRT_ST_RESET); // pull low only when asserted
    s_d.rst_n = !s_d.oe;
    s_d.drv = 1'h0;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_q <= '{st: pbrt_pkg::PBRT_ST_STARTUP, sel: 1'h0, oe: 1'h0, rst_n: 1'h1,
               drv: 1'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // open drain: data is always low, the enable does the work
  assign O_RESET_OUT = s_q.drv;
  assign O_RESET_OE = s_q.oe;
  assign O_RESET_ACTIVE_N = s_q.rst_n;
endmodule

/* File: sim/pbrt_checker.sv */
/* checker on pbrt_top ports; timing checks fit the fixed-pulse dual build only.
   assumes the bind hands on the short counts. */
`timescale 1ns/100ps
module pbrt_checker #(parameter int HOLD_LOW_CYC = 200, DETECT_CYC = 30,
  PULSE_G_CYC = 100, STARTUP_CYC = 20, parameter bit FIXED = 1'h1) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic I_FIRST_BUTTON_IN_N,
  input wire logic I_SECOND_BUTTON_IN_N,
  input wire logic I_DELAY_SELECT,
  input wire logic O_RESET_OUT,
  input wire logic O_RESET_OE,
  input wire logic O_RESET_ACTIVE_N
);
  logic [15:0] up_q, low_q, oe_q;
  logic rearm_q;
  wire hi = I_FIRST_BUTTON_IN_N | I_SECOND_BUTTON_IN_N;
  wire [15:0] lim = I_DELAY_SELECT ? 16'(DETECT_CYC) : 16'(HOLD_LOW_CYC);
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      {up_q, low_q, oe_q, rearm_q} <= {48'h0, 1'b1};
    end else begin
      up_q <= (up_q < STARTUP_CYC) ? up_q + 16'h1 : up_q;
      low_q <= (hi || up_q < STARTUP_CYC) ? 16'h0 : low_q + 16'h1;
      oe_q <= O_RESET_OE ? oe_q + 16'h1 : 16'h0;
      // a glitch under the pulse must not rearm
      rearm_q <= (hi && !O_RESET_OE) || (rearm_q && !$fell(O_RESET_OE));
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  // timing counts below assume a fixed pulse and both buttons
  default disable iff (!I_RESET_N || !FIXED);
  pin_low_a: assert property (disable iff (!I_RESET_N)
    O_RESET_OUT == 1'h0) else $error("data");
  level_inv_a: assert property (disable iff (!I_RESET_N)
    O_RESET_ACTIVE_N == !O_RESET_OE) else $error("lvl");
  sequence let_go_s;
    O_RESET_OE && I_FIRST_BUTTON_IN_N;
  endsequence
  sequence let_off_s;
    !O_RESET_OE;
  endsequence
  // first button high ends the reset in the input-dependent builds only, not in the fixed-pulse ones
  dep_release_a: assert property (disable iff (!I_RESET_N || FIXED)
    let_go_s |=> let_off_s) else $error("held");
  hold_min_a: assert property ($rose(O_RESET_OE) |-> low_q > lim) else $error("early");
  hold_late_a: assert property (rearm_q && low_q == lim + 4 |-> O_RESET_OE) else $error("late");
  one_shot_a: assert property ($rose(O_RESET_OE) |-> rearm_q) else $error("again");
  start_quiet_a: assert property (up_q < STARTUP_CYC |-> !O_RESET_OE) else $error("su");
  pulse_min_a: assert property ($fell(O_RESET_OE) |-> $past(oe_q) >= PULSE_G_CYC) else $error("short");
  pulse_max_a: assert property (oe_q <= PULSE_G_CYC + 3) else $error("long");
endmodule
bind pbrt_top pbrt_checker #(.HOLD_LOW_CYC(HOLD_LOW_CYC), .DETECT_CYC(DETECT_CYC),
  .PULSE_G_CYC(PULSE_G_CYC), .STARTUP_CYC(STARTUP_CYC),
  .FIXED(VARIANT != pbrt_pkg::PBRT_INPUT_DEP)) pbrt_checker_inst (.*);

/* File: sim/pbrt_partner.sv */
/* partner: pulled-up reset line at the system input.
   assumes enable high means the pin pulls low. */
`timescale 1ns/100ps
module pbrt_partner (
  input wire logic i_oe,
  input wire logic i_out,
  output logic o_line
);
  assign o_line = i_oe ? i_out : 1'b1; // pull-up when released
endmodule

/* File: sim/tb_pushbutton_reset_timer.sv */
/* testbench: fixed-pulse dual and input-dependent single timers, short counts.
   assumes the partner resolves the reset line. */
`timescale 1ns/100ps
module tb_pushbutton_reset_timer;
  localparam int HOLD = 200, DET = 30, PULSE = 100, SU = 20, HIN = 300;
  logic clk = 0, rst_n = 0, b1 = 0, b2 = 0, sel = 0, d1 = 1;
  logic r_out, r_oe, line, s_out, s_oe, s_line;
  int num_errors = 0, samples_checked = 0;
  initial forever #2.5 clk = ~clk;
  pbrt_top #(.HOLD_LOW_CYC(HOLD), .PULSE_G_CYC(PULSE), .DETECT_CYC(DET), .STARTUP_CYC(SU))
    pbrt_top_inst (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_FIRST_BUTTON_IN_N(b1),
    .I_SECOND_BUTTON_IN_N(b2), .I_DELAY_SELECT(sel), .O_RESET_OUT(r_out),
    .O_RESET_OE(r_oe), .O_RESET_ACTIVE_N());
  pbrt_partner pbrt_partner_inst (.i_oe(r_oe), .i_out(r_out), .o_line(line));
  // second pin driven opposite to the first: a dual build could never fire
  pbrt_top #(.VARIANT(pbrt_pkg::PBRT_INPUT_DEP), .DUAL_INPUT(1'h0), .HOLD_LOW_CYC(HOLD),
    .HOLD_HIGH_IN_CYC(HIN), .DETECT_CYC(DET), .STARTUP_CYC(SU))
    pbrt_top_single_inst (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_FIRST_BUTTON_IN_N(d1),
    .I_SECOND_BUTTON_IN_N(!d1), .I_DELAY_SELECT(sel), .O_RESET_OUT(s_out),
    .O_RESET_OE(s_oe), .O_RESET_ACTIVE_N());
  pbrt_partner pbrt_partner_single_inst (.i_oe(s_oe), .i_out(s_out), .o_line(s_line));
  task finish_test;
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reach: line must get to lvl within lo..hi; else it must not by hi
  task w(logic lvl, int lo, int hi, bit reach, bit one = 1'h0);
    int c;
    logic v;
    c = 0;
    v = one ? s_line : line;
    while (v !== lvl && c < hi) begin
      @(negedge clk);
      c++;
      v = one ? s_line : line;
    end
    samples_checked++;
    if (reach ? (v !== lvl || c < lo) : (v === lvl)) begin
      num_errors++;
      $display("mismatch %0t line %b after %0d", $time, v, c);
      if (reach && v !== lvl) finish_test;
    end
  endtask
  task s_power;
    w(0, SU + HOLD, SU + HOLD + 5, 1);
    repeat (20) @(negedge clk);
    b1 = 1;
    @(negedge clk);
    b1 = 0;
    w(1, PULSE - 21, PULSE - 17, 1);
    w(0, HOLD + 9, HOLD + 9, 0);
  endtask
  task s_restart;
    b1 = 1;
    @(negedge clk);
    b1 = 0;
    w(0, HOLD - 9, HOLD - 9, 0);
    b2 = 1;
    @(negedge clk);
    b2 = 0;
    w(0, HOLD, HOLD + 5, 1);
    w(1, 1, PULSE + 5, 1);
    b2 = 1;
    w(0, HOLD + 9, HOLD + 9, 0);
  endtask
  task s_zero;
    sel = 1; // changed only while a button is high
    @(negedge clk);
    b2 = 0;
    w(0, DET, DET + 5, 1);
    w(1, 1, PULSE + 5, 1);
    b1 = 1;
    b2 = 1;
    sel = 0; // normal tie for operation
    @(negedge clk);
    b1 = 0;
    b2 = 0;
    w(0, HOLD, HOLD + 5, 1);
  endtask
  task s_single;
    b1 = 1;
    d1 = 0;
    w(0, HOLD, HOLD + 5, 1, 1);
    w(1, HOLD, HOLD, 0, 1);
    d1 = 1;
    w(1, 1, 1, 1, 1);
    sel = 1; // changed only while the first button is high
    @(negedge clk);
    d1 = 0;
    w(0, HIN, HIN + 5, 1, 1);
    d1 = 1;
    w(1, 1, 1, 1, 1);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    s_power;
    s_restart;
    s_zero;
    s_single;
    finish_test;
  end
endmodule
